//--- verilog/fau_unit.sv
// Floating arithmetic unit: registers, condition flags, trap and busy control.
// Operation
// [RULE_01] Arithmetic uses 39-bit signed mantissa and 8-bit signed exponent.
// [RULE_02] Integer loads are normalised and converted to float first.
// [RULE_03] Double loads are taken as normalised; lower half bit 23 dropped.
// [RULE_04] Decimal condition codes write condition bits 3-0.
// [RULE_05] Software reinitialises condition register between decimal and float runs.
// [RULE_06] After exponent change, condition reflects that result, not the mantissa.
// [RULE_07] Trap fires when enabled and overflow bit 0 becomes one.
// [RULE_08] Release sets trap enable; hold clears it.
// [RULE_09] External interrupt hold also gates trap delivery.
// [RULE_10] Software clears overflow before releasing the trap.
// [RULE_11] Positive flag set when result above zero, else cleared.
// [RULE_12] Negative flag set when result below zero, else cleared.
// [RULE_13] Zero flag set on zero mantissa with exponent octal 201.
// [RULE_14] Compare sets equal flag or less-than flag.
// [RULE_15] Overflow set when exponent exceeds +127 or falls below -128.
// [RULE_16] Square root of negative mantissa sets its flag.
// [RULE_17] Divide by zero sets its flag.
// [RULE_18] Trapped overflow makes unit busy, refusing all but hold and decimals; the code refuses decimals while busy too.
// [RULE_19] Service routine holds first, clears overflow, then releases.
// [RULE_20] Loading condition with bit 0 set traps like real overflow.
// [RULE_21] Software keeps float instructions consecutive where overflow likely.
// [RULE_22] Flags: 0 ovf, 1 eq, 2 lt, 3 sqrt, 4 divz, 5 zero, 6 neg, 7 pos.
`timescale 1ns/1ps
module fau_unit
	import fau_pkg::*;
(
	input  wire logic                 sys_clk,
	input  wire logic                 sys_rst,
	input  wire logic                 cmd_valid,
	input  wire fau_cmd_t             cmd,
	input  wire logic                 dec_valid,
	input  wire logic [3:0]           dec_cond,
	input  wire logic                 ext_int_held,
	output logic                      cmd_accept,
	output logic                      cmd_refused,
	output logic                      dec_refused,
	output logic                      busy,
	output logic                      trap_enable,
	output logic                      trap_req,
	output fau_float_t                acc,
	output logic [COND_W-1:0]         cond
);
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_BUSY = 1'b1
	} fau_state_t;

	fau_state_t state;
	fau_float_t norm_val;
	fau_float_t next_acc;
	logic [COND_W-1:0] next_cond;
	logic signed [EXP_W+1:0] res_exp;
	logic signed [MANT_W-1:0] res_mant;
	logic signed [MANT_W-1:0] opnd_mant;
	logic signed [2*MANT_W-1:0] prod;
	logic f_pos;
	logic f_neg;
	logic f_zero;
	logic f_ovf;
	logic arith;
	logic take;
	logic ovf_prev;

	fau_normalize u_norm (
		.int_in  (cmd.lower),
		.flt_out (norm_val)
	);

	fau_flags u_flags (
		.mant     (res_mant),
		.wide_exp (res_exp),
		.pos      (f_pos),
		.neg      (f_neg),
		.zero     (f_zero),
		.ovf      (f_ovf)
	);

	// Only hold is accepted while busy; everything else but nop is refused.
	assign take = cmd_valid && cmd.op != FAU_NOP
		&& (state == ST_IDLE || cmd.op == FAU_HOLD);                   // [RULE_18]

	// Operand for arithmetic: upper word holds the top 24 mantissa bits, lower
	// the next 15 bits and the exponent. Arithmetic is a simplified datapath; the
	// full algorithms live elsewhere, the flags and trap behaviour are exact.
	always_comb begin
		opnd_mant = {cmd.upper, cmd.lower[22:8]};
		prod      = acc.mant * opnd_mant;
		res_mant  = acc.mant;
		res_exp   = {{2{acc.expo[EXP_W-1]}}, acc.expo};
		arith     = 1'b1;
		unique case (cmd.op)
			FAU_ADD: begin
				res_mant = acc.mant + opnd_mant;
			end
			FAU_SUB: begin
				res_mant = acc.mant - opnd_mant;
			end
			FAU_MUL: begin
				res_mant = prod[2*MANT_W-2 -: MANT_W];
				res_exp  = res_exp + {{2{cmd.lower[7]}}, cmd.lower[7:0]};
			end
			FAU_DIV: begin
				res_exp  = res_exp - {{2{cmd.lower[7]}}, cmd.lower[7:0]};
			end
			FAU_SCALE: begin
				res_exp  = res_exp + {{2{cmd.lower[7]}}, cmd.lower[7:0]}; // [RULE_06]
			end
			default: begin
				arith = 1'b0;
			end
		endcase
	end

	// Register datapath.
	always_comb begin
		next_acc = acc;
		if (take) begin
			unique case (cmd.op)
				FAU_LOAD_INT: next_acc = norm_val;                          // [RULE_02]
				FAU_LOAD_DBL: begin
					next_acc.mant = {cmd.upper, cmd.lower[DROP_BIT-1:8]};   // [RULE_03]
					next_acc.expo = cmd.lower[EXP_W-1:0];
				end
				FAU_ADD, FAU_SUB, FAU_MUL, FAU_SCALE: begin
					next_acc.mant = res_mant;                               // [RULE_01]
					next_acc.expo = res_exp[EXP_W-1:0];
				end
				FAU_DIV: begin
					if (opnd_mant != '0) begin
						next_acc.expo = res_exp[EXP_W-1:0];
					end
				end
				default: next_acc = acc;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			acc <= '0;
		end else begin
			acc <= next_acc;
		end
	end

	// Condition register.
	always_comb begin
		next_cond = cond;
		if (take) begin
			unique case (cmd.op)
				FAU_LOAD_COND: next_cond = cmd.cond;                        // [RULE_20]
				FAU_LOAD_INT, FAU_LOAD_DBL: next_cond[COND_OVF] = 1'b0;
				FAU_CMP: begin
					next_cond[COND_CEQ] = (opnd_mant == acc.mant);          // [RULE_14]
					next_cond[COND_CLT] = (opnd_mant < acc.mant);           // [RULE_14]
				end
				FAU_SQRT: begin
					if (acc.mant[MANT_W-1]) begin
						next_cond[COND_SQRT] = 1'b1;                        // [RULE_16]
					end
				end
				default: begin
					if (cmd.op == FAU_DIV && opnd_mant == '0) begin
						next_cond[COND_DIVZ] = 1'b1;                        // [RULE_17]
					end else if (arith) begin
						next_cond[COND_POS]  = f_pos;
						next_cond[COND_NEG]  = f_neg;
						next_cond[COND_ZERO] = f_zero;
						if (f_ovf) begin
							next_cond[COND_OVF] = 1'b1;                     // [RULE_15]
						end
					end
				end
			endcase
		end else if (dec_valid && state == ST_IDLE) begin
			next_cond[3:0] = dec_cond & DEC_MASK;                           // [RULE_04]
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cond <= COND_RESET;                                             // [RULE_22]
		end else begin
			cond <= next_cond;
		end
	end

	// Trap enable: release sets, hold clears.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			trap_enable <= 1'b0;
		end else if (take && cmd.op == FAU_RELEASE) begin
			trap_enable <= 1'b1;                                            // [RULE_08]
		end else if (take && cmd.op == FAU_HOLD) begin
			trap_enable <= 1'b0;                                            // [RULE_08]
		end
	end

	// Rising edge of the overflow bit is the trap event.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ovf_prev <= 1'b0;
		end else begin
			ovf_prev <= cond[COND_OVF];
		end
	end

	// A rising overflow while enabled enters busy; hold leaves it.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_IDLE;
		end else if (take && cmd.op == FAU_HOLD) begin
			state <= ST_IDLE;
		end else if (trap_enable && cond[COND_OVF] && !ovf_prev) begin
			state <= ST_BUSY;                                               // [RULE_18]
		end
	end

	// The request stays pending while external interrupts are held, so the
	// trap is delayed, not lost.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			trap_req <= 1'b0;
		end else begin
			trap_req <= state == ST_BUSY && trap_enable && !ext_int_held;   // [RULE_07] [RULE_09]
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cmd_accept  <= 1'b0;
			cmd_refused <= 1'b0;
			dec_refused <= 1'b0;
			busy        <= 1'b0;
		end else begin
			cmd_accept  <= take;
			cmd_refused <= cmd_valid && cmd.op != FAU_NOP && !take;         // [RULE_18]
			dec_refused <= dec_valid && state == ST_BUSY;                   // [RULE_18]
			busy        <= state == ST_BUSY
				&& !(take && cmd.op == FAU_HOLD);
		end
	end

endmodule // fau_unit

//--- verilog/fau_pkg.sv
// Shared constants and carrier types for the floating arithmetic unit.
package fau_pkg;

	localparam int MANT_W = 39;
	localparam int EXP_W  = 8;
	localparam int WORD_W = 24;
	localparam int COND_W = 8;

	// Condition register bit positions.
	localparam int COND_OVF  = 0;
	localparam int COND_CEQ  = 1;
	localparam int COND_CLT  = 2;
	localparam int COND_SQRT = 3;
	localparam int COND_DIVZ = 4;
	localparam int COND_ZERO = 5;
	localparam int COND_NEG  = 6;
	localparam int COND_POS  = 7;

	localparam logic [COND_W-1:0] COND_RESET = 8'h00;
	localparam logic [EXP_W-1:0]  EXP_ZERO   = 8'h81;
	localparam logic [3:0]        DEC_MASK   = 4'hf;
	localparam int                DROP_BIT   = 23;
	localparam logic [5:0]        NORM_SHIFT = 6'h26;

	typedef enum logic [3:0] {
		FAU_NOP      = 4'b0000,
		FAU_LOAD_INT = 4'b0001,
		FAU_LOAD_DBL = 4'b0010,
		FAU_ADD      = 4'b0011,
		FAU_SUB      = 4'b0100,
		FAU_MUL      = 4'b0101,
		FAU_DIV      = 4'b0110,
		FAU_SQRT     = 4'b0111,
		FAU_CMP      = 4'b1000,
		FAU_SCALE    = 4'b1001,
		FAU_LOAD_COND = 4'b1010,
		FAU_HOLD     = 4'b1011,
		FAU_RELEASE  = 4'b1100
	} fau_op_t;

	typedef struct packed {
		logic signed [MANT_W-1:0] mant;
		logic signed [EXP_W-1:0]  expo;
	} fau_float_t;

	typedef struct packed {
		fau_op_t             op;
		logic [WORD_W-1:0]   upper;
		logic [WORD_W-1:0]   lower;
		logic [COND_W-1:0]   cond;
	} fau_cmd_t;

endpackage

//--- verilog/fau_normalize.sv
// Integer-to-float normaliser for word loads into the mantissa register.
`timescale 1ns/1ps
module fau_normalize
	import fau_pkg::*;
(
	input  wire logic [WORD_W-1:0] int_in,
	output fau_float_t             flt_out
);
	logic [MANT_W-1:0] ext;
	logic [5:0]        sh;
	logic [MANT_W-1:0] shifted;

	// The sign-extended integer is shifted until the sign bit differs from the bit below.
	always_comb begin
		ext     = {{(MANT_W-WORD_W){int_in[WORD_W-1]}}, int_in};
		sh      = 6'h00;
		shifted = ext;
		for (int i = 0; i < MANT_W-1; i++) begin
			if (shifted[MANT_W-1] == shifted[MANT_W-2] && shifted != '0) begin
				shifted = shifted << 1;
				sh      = sh + 6'h01;
			end
		end
	end

	assign flt_out.mant = shifted;
	// The binary point sits below the sign bit, so every shift costs one power of two.
	assign flt_out.expo = (shifted == '0) ? EXP_ZERO
		: EXP_W'(NORM_SHIFT - sh);

endmodule // fau_normalize

//--- verilog/fau_flags.sv
// Result flag generator for arithmetic and scaling operations.
`timescale 1ns/1ps
module fau_flags
	import fau_pkg::*;
(
	input  wire logic signed [MANT_W-1:0] mant,
	input  wire logic signed [EXP_W+1:0]  wide_exp,
	output logic                          pos,
	output logic                          neg,
	output logic                          zero,
	output logic                          ovf
);
	always_comb begin
		pos  = !mant[MANT_W-1] && mant != '0;                          // [RULE_11]
		neg  = mant[MANT_W-1];                                          // [RULE_12]
		zero = (mant == '0) && (wide_exp[EXP_W-1:0] == EXP_ZERO);       // [RULE_13]
		ovf  = (wide_exp > 10'sd127) || (wide_exp < -10'sd128);         // [RULE_15]
	end

endmodule // fau_flags

//--- verification/fau_unit_assertions.sv
// Port-level checks of the floating arithmetic unit.
`timescale 1ns/1ps
module fau_unit_assertions
	import fau_pkg::*;
(
	input wire logic              sys_clk,
	input wire logic              sys_rst,
	input wire logic              cmd_valid,
	input wire fau_cmd_t          cmd,
	input wire logic              dec_valid,
	input wire logic [3:0]        dec_cond,
	input wire logic              ext_int_held,
	input wire logic              cmd_accept,
	input wire logic              cmd_refused,
	input wire logic              dec_refused,
	input wire logic              busy,
	input wire logic              trap_enable,
	input wire logic              trap_req,
	input wire fau_float_t        acc,
	input wire logic [COND_W-1:0] cond
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	sequence ovf_rise;
		trap_enable && $rose(cond[COND_OVF]) && !ext_int_held && !cmd_valid;
	endsequence
	sequence quiet;
		!cmd_valid && !ext_int_held;
	endsequence
	AST_TRAP: assert property (ovf_rise ##1 quiet |=> busy && trap_req)
		else $error("overflow did not trap");
	AST_GATE: assert property (ext_int_held && $past(ext_int_held) |-> !trap_req)
		else $error("trap while interrupts held");
	AST_RELEASE: assert property (cmd_valid && cmd.op == FAU_RELEASE |=> trap_enable)
		else $error("release did not enable");
	AST_HOLD: assert property (cmd_valid && cmd.op == FAU_HOLD |=> cmd_accept && !trap_enable && !busy)
		else $error("hold not taken");
	AST_REFUSE: assert property (busy && cmd_valid && !(cmd.op inside {FAU_HOLD, FAU_NOP})
		|=> cmd_refused && !cmd_accept && $stable(cond))
		else $error("command taken while busy");
	AST_DEC_REF: assert property (busy && dec_valid && !cmd_valid |=> dec_refused && $stable(cond))
		else $error("decimal taken while busy");
	AST_DEC_WR: assert property (dec_valid && !cmd_valid && !busy && !(trap_enable && cond[COND_OVF])
		|=> cond[3:0] == $past(dec_cond) && cond[7:4] == $past(cond[7:4]))
		else $error("decimal codes not written");
	AST_DIVZ: assert property (cmd_valid && cmd.op == FAU_DIV && cmd.upper == '0 && cmd.lower[22:8] == '0
		|=> cmd_accept |-> cond[COND_DIVZ])
		else $error("divide by zero flag missing");
	AST_BUSY_EN: assert property (busy |-> trap_enable)
		else $error("busy without trap enable");
endmodule // fau_unit_assertions

bind fau_unit fau_unit_assertions i_fau_unit_assertions (.sys_clk(sys_clk), .sys_rst(sys_rst),
	.cmd_valid(cmd_valid), .cmd(cmd), .dec_valid(dec_valid), .dec_cond(dec_cond),
	.ext_int_held(ext_int_held), .cmd_accept(cmd_accept), .cmd_refused(cmd_refused),
	.dec_refused(dec_refused), .busy(busy), .trap_enable(trap_enable), .trap_req(trap_req),
	.acc(acc), .cond(cond));

//--- verification/fau_host.sv
// Host processor model: external interrupt hold and trap counting.
`timescale 1ns/1ps
module fau_host (
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	input  wire logic hold_ext,
	input  wire logic trap_req,
	output logic      ext_int_held,
	output int        traps
);
	logic seen;
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ext_int_held <= 1'b0;
			seen <= 1'b0;
			traps <= 0;
		end else begin
			ext_int_held <= hold_ext;
			seen <= trap_req;
			if (trap_req && !seen) begin
				traps <= traps + 1;
			end
		end
	end
endmodule // fau_host

//--- verification/float_unit_condition_and_trap_bench.sv
// Self-checking bench of the floating arithmetic unit.
`timescale 1ns/1ps
module float_unit_condition_and_trap_bench;
	import fau_pkg::*;
	logic sys_clk = 1'b0, sys_rst = 1'b1, cmd_valid = 1'b0, dec_valid = 1'b0, hold_ext = 1'b0;
	logic [3:0] dec_cond = 4'h0;
	fau_cmd_t cmd = '0;
	logic cmd_accept, cmd_refused, dec_refused, busy, trap_enable, trap_req, ext_int_held;
	fau_float_t acc;
	logic [COND_W-1:0] cond;
	int traps, miscompares = 0, check_count = 0;
	always #2 sys_clk = ~sys_clk;
	fau_unit i_fau_unit (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
		.dec_valid(dec_valid), .dec_cond(dec_cond), .ext_int_held(ext_int_held),
		.cmd_accept(cmd_accept), .cmd_refused(cmd_refused), .dec_refused(dec_refused),
		.busy(busy), .trap_enable(trap_enable), .trap_req(trap_req), .acc(acc), .cond(cond));
	fau_host i_fau_host (.sys_clk(sys_clk), .sys_rst(sys_rst), .hold_ext(hold_ext),
		.trap_req(trap_req), .ext_int_held(ext_int_held), .traps(traps));
	task chk(input string nm, input logic [46:0] seen, input logic [46:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task issue(input fau_op_t op, input logic [23:0] up, input logic [23:0] lo, input logic [7:0] c);
		@(posedge sys_clk);
		cmd_valid <= 1'b1;
		cmd <= '{op, up, lo, c};
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		#1;
	endtask
	task dec(input logic [3:0] d);
		@(posedge sys_clk);
		dec_valid <= 1'b1;
		dec_cond <= d;
		@(posedge sys_clk);
		dec_valid <= 1'b0;
		#1;
	endtask
	task t_decimal;
		issue(FAU_LOAD_COND, 24'h0, 24'h0, 8'hf0);
		dec(4'h6);
		chk("dec cond", cond, 8'hf6);
		issue(FAU_LOAD_COND, 24'h0, 24'h0, 8'h00);
	endtask
	task t_load_div;
		// Bit 23 of the lower half must not reach the mantissa.
		issue(FAU_LOAD_DBL, 24'h400000, 24'h800000, 8'h00);
		chk("acc", acc, {24'h400000, 15'h0, 8'h00});
		issue(FAU_CMP, 24'h400000, 24'h000000, 8'h00);
		chk("cmp", cond[2:1], 2'b01);
		issue(FAU_DIV, 24'h0, 24'h0, 8'h00);
		chk("div accept", cmd_accept, 1'b1);
		chk("div zero", cond[COND_DIVZ], 1'b1);
	endtask
	// Float instructions follow one another here, one idle cycle apart, as overflow is expected.
	task t_flags;
		issue(FAU_LOAD_COND, 24'h0, 24'h0, 8'h00);
		issue(FAU_LOAD_DBL, 24'h400000, 24'h000081, 8'h00);
		issue(FAU_SUB, 24'h400000, 24'h000000, 8'h00);
		chk("zero flag", cond, 8'h20);
		issue(FAU_SUB, 24'h400000, 24'h000000, 8'h00);
		chk("neg flag", cond, 8'h40);
		issue(FAU_SQRT, 24'h0, 24'h0, 8'h00);
		chk("sqrt flag", cond, 8'h48);
		issue(FAU_ADD, 24'h7fffff, 24'h000000, 8'h00);
		chk("pos flag", cond, 8'h88);
		issue(FAU_SCALE, 24'h0, 24'h00007f, 8'h00);
		chk("scale expo", 47'(acc.expo), 47'h0);
		chk("scale cond", cond, 8'h88);
		issue(FAU_SCALE, 24'h0, 24'h00007f, 8'h00);
		chk("no ovf", cond, 8'h88);
		issue(FAU_SCALE, 24'h0, 24'h000001, 8'h00);
		chk("ovf", cond, 8'h89);
		chk("no trap when held", busy, 1'b0);
		issue(FAU_LOAD_INT, 24'h0, 24'h000001, 8'h00);
		chk("int load", acc, {39'h2000000000, 8'h01});
		chk("int load clears ovf", cond, 8'h88);
		issue(FAU_LOAD_COND, 24'h0, 24'h0, 8'h00);
	endtask
	task t_trap;
		issue(FAU_LOAD_COND, 24'h0, 24'h0, 8'h00);
		issue(FAU_RELEASE, 24'h0, 24'h0, 8'h00);
		chk("enable", trap_enable, 1'b1);
		issue(FAU_LOAD_COND, 24'h0, 24'h0, 8'h01);
		repeat (2) @(posedge sys_clk);
		#1;
		chk("busy", busy, 1'b1);
		chk("trap", trap_req, 1'b1);
		issue(FAU_ADD, 24'h400000, 24'h0, 8'h00);
		chk("refused", cmd_refused, 1'b1);
		dec(4'hf);
		chk("dec refused", dec_refused, 1'b1);
		chk("cond kept", cond, 8'h01);
		issue(FAU_HOLD, 24'h0, 24'h0, 8'h00);
		chk("idle", {busy, trap_enable}, 2'b00);
		issue(FAU_LOAD_COND, 24'h0, 24'h0, 8'h00);
		issue(FAU_RELEASE, 24'h0, 24'h0, 8'h00);
		chk("no spurious", {busy, trap_req}, 2'b00);
	endtask
	task t_gate;
		@(posedge sys_clk);
		hold_ext <= 1'b1;
		issue(FAU_HOLD, 24'h0, 24'h0, 8'h00);
		issue(FAU_RELEASE, 24'h0, 24'h0, 8'h00);
		issue(FAU_LOAD_COND, 24'h0, 24'h0, 8'h01);
		repeat (2) @(posedge sys_clk);
		#1;
		chk("held busy", busy, 1'b1);
		chk("held trap", trap_req, 1'b0);
		@(posedge sys_clk);
		hold_ext <= 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
		chk("late trap", trap_req, 1'b1);
		chk("traps", 47'(traps), 47'd2);
		issue(FAU_HOLD, 24'h0, 24'h0, 8'h00);
	endtask
	task results;
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#20000;
		miscompares++;
		results();
	end
	initial begin
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		#1;
		chk("reset ctl", 47'({cond, busy, trap_enable, trap_req}), 47'h0);
		chk("reset acc", acc, 47'h0);
		t_decimal();
		t_load_div();
		t_flags();
		t_trap();
		t_gate();
		results();
	end
endmodule // float_unit_condition_and_trap_bench
